// file: shared/smr_pkg.sv
/*
 * Constants shared by both ends of the mode-register configuration link.
 * Assumes one clock domain (clk, 10 MHz) and an active-high async reset.
 */
// Function
// - Mode registers reset to all ones.
// - Each mode command takes one mask byte.
// - Set command ORs mask into register.
// - Reset command ANDs mask into register.
// - Mode commands give no result, no interrupt.
// - Flag stream bit sends flags when idle.
// - Flag stream ignored in loop or delay.
// - Flag stream cleared: idles at boundary.
// - Preframe bit: two chars, 00 or 55.
// - Buffered bit keeps first two bytes.
// - Early bit: interrupt after last data.
// - New transmit after early: no final interrupt.
// - Early cleared: interrupt after closing flag.
// - Host keeps end-of-process bit cleared; reset leaves it set, and the host clears it only in set masks.
// - Abort bit cleared: SDLC abort character.
// - Serial bit 0 selects NRZI coding.
// - Serial bit 1 loops transmit clock.
// - Serial bit 2 loops transmit data.
// - Transfer register set: interrupt per byte.
// - Host: result flag clear means data request.
// - Transfer register cleared: DMA, no interrupts; tx_end_int still drives the transmit interrupt line.
// - Delay register selects one-bit retransmit.
// - Host waits parameter buffer empty first.
package smr_pkg;
	localparam logic [7:0] CMD_SET_DELAY = 8'hA4;
	localparam logic [7:0] CMD_RST_DELAY = 8'h64;
	localparam logic [7:0] CMD_SET_XFER = 8'h97;
	localparam logic [7:0] CMD_RST_XFER = 8'h57;
	localparam logic [7:0] CMD_SET_OPER = 8'h91;
	localparam logic [7:0] CMD_RST_OPER = 8'h51;
	localparam logic [7:0] CMD_SET_SIO = 8'hA0;
	localparam logic [7:0] CMD_RST_SIO = 8'h60;
	localparam logic [7:0] MODE_RESET = 8'hFF;
	localparam logic [7:0] OPER_USED = 8'h3F;
	localparam logic [7:0] SIO_USED = 8'h07;
	localparam logic [7:0] ONE_USED = 8'h01;
	localparam logic [7:0] PREFRAME_NRZI = 8'h00;
	localparam logic [7:0] PREFRAME_PLAIN = 8'h55;
	localparam int OPER_FLAG_STREAM = 0;
	localparam int OPER_PREFRAME = 1;
	localparam int OPER_BUFFERED = 2;
	localparam int OPER_EARLY_TX = 3;
	localparam int OPER_END_OF_PROCESS = 4;
	localparam int OPER_HDLC_ABORT = 5;
	localparam int SIO_NRZI = 0;
	localparam int SIO_CLK_LOOP = 1;
	localparam int SIO_DATA_LOOP = 2;
	localparam int XFER_INTR = 0;
	localparam int DELAY_ON = 0;
	localparam logic [1:0] HREG_STATUS = 2'h0;
	localparam logic [1:0] HREG_CMD = 2'h1;
	localparam logic [1:0] HREG_PARAM = 2'h2;
	typedef enum logic [1:0] {
		SMR_IDLE = 2'b00,
		SMR_WAIT_PARAM = 2'b01
	} smr_dev_state_t;
	typedef enum logic [1:0] {
		SMR_H_IDLE = 2'b00,
		SMR_H_CMD = 2'b01,
		SMR_H_WAIT = 2'b10,
		SMR_H_PARAM = 2'b11
	} smr_host_state_t;
endpackage : smr_pkg

// file: shared/smr_if.sv
/*
 * Link between the host end and the device end of the mode configuration.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface smr_if;
	logic [7:0] cmd_data;
	logic cmd_wr;
	logic [7:0] param_data;
	logic param_wr;
	logic command_busy;
	logic parameter_buffer_full_flag;
	logic result_buffer_full;
	logic completion_int;
	modport host (
		output cmd_data, cmd_wr, param_data, param_wr,
		input command_busy, parameter_buffer_full_flag,
		input result_buffer_full, completion_int
	);
	modport device (
		input cmd_data, cmd_wr, param_data, param_wr,
		output command_busy, parameter_buffer_full_flag,
		output result_buffer_full, completion_int
	);
endinterface : smr_if
`default_nettype wire

// file: core/smr_device.sv
/*
 * Device end: the four mode registers and the controls derived from them.
 * The registers change only through a set or reset command followed by
 * its mask; the other outputs decode their bits, some of them together with the transmitter inputs.
 * Assumes the host writes one command then one parameter per sequence.
 * Assumes every transmitter input is a pulse or level on clk, active
 * high, so none of them passes a synchroniser.
 */
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module smr_device (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Link to the host.
	smr_if.device link,
	// Transmitter state.
	input wire logic tx_active,
	input wire logic char_boundary,
	input wire logic loop_transmit,
	input wire logic last_data_taken,
	input wire logic final_flag_sent,
	input wire logic new_tx_cmd,
	input wire logic tx_data_need,
	input wire logic rx_data_ready,
	// Mode register contents.
	output logic [7:0] operating_mode,
	output logic [7:0] serial_io_mode,
	output logic [7:0] data_transfer_mode,
	output logic [7:0] one_bit_delay_mode,
	// Derived controls.
	output logic send_flags,
	output logic preframe_enable,
	output logic [7:0] preframe_char,
	output logic buffered_mode,
	output logic hdlc_abort,
	output logic nrzi_enable,
	output logic clock_loopback,
	output logic data_loopback,
	output logic one_bit_delay,
	output logic tx_end_int,
	output logic transmit_interrupt_line,
	output logic receive_interrupt_line,
	output logic tx_dma_req,
	output logic rx_dma_req
);
	////////////////////////////////////////////////////////////////////
	smr_pkg::smr_dev_state_t state_q;
	logic [7:0] cmd_q;
	logic flag_q;
	logic early_seen_q;
	logic chain_q;
	logic op_set;
	logic op_rst;
	logic flags_blocked;
	logic per_byte;

	function automatic logic [7:0] apply_mask(input logic [7:0] old,
		input logic [7:0] mask, input logic is_set, input logic [7:0] used);
		logic [7:0] r;
		r = is_set ? (old | mask) : (old & mask);
		apply_mask = (r & used) | (old & ~used);
	endfunction : apply_mask

	// Set codes carry bit 7 high, reset codes carry it low.
	function automatic logic set_command(input logic [7:0] code);
		set_command = code[7];
	endfunction : set_command

	////////////////////////////////////////////////////////////////////
	// Command phase: a mode command waits for exactly one parameter.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= smr_pkg::SMR_IDLE;
			cmd_q <= 8'h00;
		end else if (link.cmd_wr) begin
			state_q <= smr_pkg::SMR_WAIT_PARAM;
			cmd_q <= link.cmd_data;
		end else if (link.param_wr) begin
			state_q <= smr_pkg::SMR_IDLE;
		end
	end

	assign link.command_busy = (state_q == smr_pkg::SMR_WAIT_PARAM);
	// The parameter is consumed in the cycle it arrives, so the buffer
	// never reads full; host polling still works unchanged.
	assign link.parameter_buffer_full_flag = 1'b0;
	assign link.result_buffer_full = 1'b0;
	assign link.completion_int = 1'b0;

	assign op_set = link.param_wr && state_q == smr_pkg::SMR_WAIT_PARAM;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			operating_mode <= smr_pkg::MODE_RESET;
			serial_io_mode <= smr_pkg::MODE_RESET;
			data_transfer_mode <= smr_pkg::MODE_RESET;
			one_bit_delay_mode <= smr_pkg::MODE_RESET;
		end else if (op_set) begin
			unique case (cmd_q)
			smr_pkg::CMD_SET_OPER, smr_pkg::CMD_RST_OPER: begin
				operating_mode <= apply_mask(operating_mode, link.param_data,
					set_command(cmd_q), smr_pkg::OPER_USED);
			end
			smr_pkg::CMD_SET_SIO, smr_pkg::CMD_RST_SIO: begin
				serial_io_mode <= apply_mask(serial_io_mode, link.param_data,
					set_command(cmd_q), smr_pkg::SIO_USED);
			end
			smr_pkg::CMD_SET_XFER, smr_pkg::CMD_RST_XFER: begin
				data_transfer_mode <= apply_mask(data_transfer_mode,
					link.param_data, set_command(cmd_q), smr_pkg::ONE_USED);
			end
			smr_pkg::CMD_SET_DELAY, smr_pkg::CMD_RST_DELAY: begin
				one_bit_delay_mode <= apply_mask(one_bit_delay_mode,
					link.param_data, set_command(cmd_q), smr_pkg::ONE_USED);
			end
			default: begin
				// An unknown code still eats its mask, keeping pairs aligned.
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flag stream: bit changes take effect only when the transmitter is idle
	// at a character boundary, so a frame in progress is never cut.
	assign flags_blocked = loop_transmit ||
		one_bit_delay_mode[smr_pkg::DELAY_ON];
	assign op_rst = operating_mode[smr_pkg::OPER_FLAG_STREAM] &&
		!flags_blocked;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else if (!tx_active && char_boundary) begin
			flag_q <= op_rst;
		end
	end
	// Only loop and delay cut flags at once; a cleared bit waits its turn.
	assign send_flags = flag_q && !flags_blocked;

	////////////////////////////////////////////////////////////////////
	// Static controls.
	assign preframe_enable = operating_mode[smr_pkg::OPER_PREFRAME];
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			preframe_char <= smr_pkg::PREFRAME_NRZI;
		end else begin
			preframe_char <= serial_io_mode[smr_pkg::SIO_NRZI] ?
				smr_pkg::PREFRAME_NRZI : smr_pkg::PREFRAME_PLAIN;
		end
	end
	assign buffered_mode = operating_mode[smr_pkg::OPER_BUFFERED];
	assign hdlc_abort = operating_mode[smr_pkg::OPER_HDLC_ABORT];
	assign nrzi_enable = serial_io_mode[smr_pkg::SIO_NRZI];
	assign clock_loopback = serial_io_mode[smr_pkg::SIO_CLK_LOOP];
	assign data_loopback = serial_io_mode[smr_pkg::SIO_DATA_LOOP];
	assign one_bit_delay = one_bit_delay_mode[smr_pkg::DELAY_ON];

	////////////////////////////////////////////////////////////////////
	// End-of-frame interrupt timing.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			early_seen_q <= 1'b0;
			chain_q <= 1'b0;
		end else begin
			if (final_flag_sent) begin
				early_seen_q <= 1'b0;
			end else if (last_data_taken &&
				operating_mode[smr_pkg::OPER_EARLY_TX]) begin
				early_seen_q <= 1'b1;
			end
			// A new command in the same cycle as the final flag loses to the flag clear.
			if (new_tx_cmd && early_seen_q && !final_flag_sent) begin
				chain_q <= 1'b1;
			end else if (final_flag_sent) begin
				chain_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_end_int <= 1'b0;
		end else if (operating_mode[smr_pkg::OPER_EARLY_TX]) begin
			// The final flag still reports unless a chained frame shares it.
			tx_end_int <= last_data_taken ||
				(final_flag_sent && !chain_q);
		end else begin
			tx_end_int <= final_flag_sent && !chain_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data transfer: per-byte interrupts or DMA requests.
	// Both paths are plain levels, so a request is never lost to a pulse
	// that the far side happened not to sample.
	assign per_byte = data_transfer_mode[smr_pkg::XFER_INTR];
	assign transmit_interrupt_line = tx_end_int ||
		(per_byte && tx_data_need);
	assign receive_interrupt_line =
		per_byte && rx_data_ready;
	assign tx_dma_req =
		!per_byte && tx_data_need;
	assign rx_dma_req =
		!per_byte && rx_data_ready;
endmodule : smr_device
`default_nettype wire

// file: core/smr_host.sv
/*
 * Host end: takes a command and mask from software registers and sends them.
 * Assumes software polls the status word for completion.
 */
`timescale 1ns/1ps
`default_nettype none
module smr_host (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Software port.
	input wire logic [1:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata,
	// Link to the device.
	smr_if.host link
);
	////////////////////////////////////////////////////////////////////
	smr_pkg::smr_host_state_t state_q;
	logic [7:0] cmd_q;
	logic [7:0] mask_q;
	logic busy;

	assign busy = (state_q != smr_pkg::SMR_H_IDLE);

	// Writing the parameter register launches the pair; a launch while
	// busy is dropped so a sequence is never split.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_q <= 8'h00;
			mask_q <= 8'h00;
		end else if (sw_wr && !busy) begin
			if (sw_addr == smr_pkg::HREG_CMD) begin
				cmd_q <= sw_wdata;
			end
			if (sw_addr == smr_pkg::HREG_PARAM) begin
				mask_q <= sw_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= smr_pkg::SMR_H_IDLE;
		end else begin
			unique case (state_q)
			smr_pkg::SMR_H_IDLE: begin
				if (sw_wr && sw_addr == smr_pkg::HREG_PARAM) begin
					state_q <= smr_pkg::SMR_H_CMD;
				end
			end
			smr_pkg::SMR_H_CMD: state_q <= smr_pkg::SMR_H_WAIT;
			smr_pkg::SMR_H_WAIT: begin
				if (!link.parameter_buffer_full_flag) begin
					state_q <= smr_pkg::SMR_H_PARAM;
				end
			end
			smr_pkg::SMR_H_PARAM: state_q <= smr_pkg::SMR_H_IDLE;
			endcase
		end
	end

	assign link.cmd_wr = (state_q == smr_pkg::SMR_H_CMD);
	assign link.cmd_data = cmd_q;
	assign link.param_wr = (state_q == smr_pkg::SMR_H_PARAM);
	// Reserved end-of-process bit is forced low on operating set commands.
	assign link.param_data = (cmd_q == smr_pkg::CMD_SET_OPER) ?
		(mask_q & ~(8'h01 << smr_pkg::OPER_END_OF_PROCESS)) :
		mask_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sw_rdata <= 8'h00;
		end else if (sw_rd) begin
			unique case (sw_addr)
			smr_pkg::HREG_STATUS: sw_rdata <= {5'h00,
				link.completion_int, link.parameter_buffer_full_flag, busy};
			smr_pkg::HREG_CMD: sw_rdata <= cmd_q;
			smr_pkg::HREG_PARAM: sw_rdata <= mask_q;
			default: sw_rdata <= 8'h00;
			endcase
		end else begin
			sw_rdata <= 8'h00;
		end
	end
endmodule : smr_host
`default_nettype wire

// file: sim/smr_link_assertions.sv
/* Checker on the command link between host end and device end.
 * Assumes one clock and the active-high async reset of the bench. */
`timescale 1ns/1ps
`default_nettype none
module smr_link_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Link signals.
	input wire logic [7:0] cmd_data,
	input wire logic cmd_wr,
	input wire logic [7:0] param_data,
	input wire logic param_wr,
	input wire logic command_busy,
	input wire logic parameter_buffer_full_flag,
	input wire logic result_buffer_full,
	input wire logic completion_int
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_open;
		cmd_wr ##1 command_busy;
	endsequence
	// The bound keeps a lost mask from hiding behind a busy phase.
	sequence s_close;
		command_busy && param_wr ##1 !command_busy;
	endsequence
	sequence s_wait;
		command_busy && !param_wr;
	endsequence
	sequence s_buf_free;
		!parameter_buffer_full_flag;
	endsequence
	AST_CMD_OPENS: assert property (cmd_wr |-> s_open)
		else $error("command did not open a phase");
	AST_MASK_CLOSES: assert property (cmd_wr |=> ##[0:3] s_close)
		else $error("mask did not close the phase in time");
	AST_BUSY_HOLDS: assert property (s_wait |=> command_busy)
		else $error("phase ended without a mask");
	AST_NO_STRAY_MASK: assert property (param_wr |-> command_busy)
		else $error("mask sent outside a phase");
	AST_ONE_MASK: assert property (param_wr |=> !param_wr)
		else $error("mask strobe longer than one cycle");
	AST_NO_OVERLAP: assert property (!(cmd_wr && param_wr))
		else $error("command and mask in one cycle");
	AST_NO_RESULT: assert property (!result_buffer_full)
		else $error("result raised by a mode command");
	AST_NO_INT: assert property (!completion_int)
		else $error("interrupt raised by a mode command");
	AST_BUF_FREE: assert property (param_wr |-> s_buf_free)
		else $error("mask written into a full buffer");
endmodule : smr_link_checker
`default_nettype wire

// file: sim/test_sdlc_mode_register_config.sv
/* Bench joining both ends over the link; software drives the host port.
 * Assumes a 10 MHz clock and status bit 0 as the busy flag. */
`timescale 1ns/1ps
`default_nettype none
module test_sdlc_mode_register_config;
	logic clk, reset, sw_wr, sw_rd, tx_active, char_boundary, loop_transmit;
	logic last_data_taken, final_flag_sent, new_tx_cmd, tx_data_need;
	logic rx_data_ready, send_flags, pe, bm, ha, nz, cl, dl, ob, tei;
	logic ti, ri, tdr, rdr;
	logic [1:0] sw_addr;
	logic [7:0] sw_wdata, sw_rdata, d, pc;
	logic [7:0] r [4];
	logic [7:0] reg_oper, reg_sio, reg_xfer, reg_delay;
	logic [7:0] e [4];
	int n_mismatch, checked;
	smr_if link ();
	smr_host smr_host_inst (.clk(clk), .reset(reset), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .link(link));
	smr_device smr_device_inst (.clk(clk), .reset(reset), .link(link),
		.tx_active(tx_active), .char_boundary(char_boundary),
		.loop_transmit(loop_transmit), .last_data_taken(last_data_taken),
		.final_flag_sent(final_flag_sent), .new_tx_cmd(new_tx_cmd),
		.tx_data_need(tx_data_need), .rx_data_ready(rx_data_ready),
		.operating_mode(reg_oper), .serial_io_mode(reg_sio),
		.data_transfer_mode(reg_xfer), .one_bit_delay_mode(reg_delay),
		.send_flags(send_flags), .preframe_enable(pe), .preframe_char(pc),
		.buffered_mode(bm), .hdlc_abort(ha), .nrzi_enable(nz),
		.clock_loopback(cl), .data_loopback(dl), .one_bit_delay(ob),
		.tx_end_int(tei), .transmit_interrupt_line(ti),
		.receive_interrupt_line(ri), .tx_dma_req(tdr), .rx_dma_req(rdr));
	smr_link_checker smr_link_checker_inst (.clk(clk), .reset(reset),
		.cmd_data(link.cmd_data), .cmd_wr(link.cmd_wr),
		.param_data(link.param_data), .param_wr(link.param_wr),
		.command_busy(link.command_busy),
		.parameter_buffer_full_flag(link.parameter_buffer_full_flag),
		.result_buffer_full(link.result_buffer_full),
		.completion_int(link.completion_int));
	always_comb begin
		r[0] = reg_oper;
		r[1] = reg_sio;
		r[2] = reg_xfer;
		r[3] = reg_delay;
	end
////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task chk(input logic [7:0] g, input logic [7:0] x);
		checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask : chk
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : wr
	task rd(input logic [1:0] a);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : rd
	// Software model: set codes OR, reset codes AND, unused bits kept.
	task cfg(input logic [7:0] c, input logic [7:0] m, input int i,
		input logic [7:0] u);
		int k;
		wr(smr_pkg::HREG_CMD, c);
		wr(smr_pkg::HREG_PARAM, m);
		if (c == smr_pkg::CMD_SET_OPER) m[4] = 1'b0;
		e[i] = c[7] ? (e[i] | (m & u)) : (e[i] & (m | ~u));
		repeat (4) @(posedge clk);
		k = 0;
		do begin
			rd(smr_pkg::HREG_STATUS);
			k++;
		end while (d[0] !== 1'b0 && k < 20);
		if (d[0] !== 1'b0) begin
			n_mismatch++;
			complete_run();
		end
		chk(d & 8'h06, 8'h00);
		chk(r[i], e[i]);
	endtask : cfg
	task ev(input logic f, input logic x);
		logic s;
		s = 1'b0;
		@(posedge clk);
		if (f) final_flag_sent <= 1'b1;
		else last_data_taken <= 1'b1;
		@(posedge clk);
		final_flag_sent <= 1'b0;
		last_data_taken <= 1'b0;
		repeat (3) begin
			#1 s = s | tei;
			@(posedge clk);
		end
		chk({7'h0, s}, {7'h0, x});
	endtask : ev
	task sf(input logic x);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			#1 if (send_flags === x) break;
		end
		chk({7'h0, send_flags}, {7'h0, x});
	endtask : sf
////////////////////////////////////////////////////////////////////////////
	task t_reset;
		for (int i = 0; i < 4; i++) chk(r[i], smr_pkg::MODE_RESET);
		chk(pc, smr_pkg::PREFRAME_NRZI);
		wr(2'h3, 8'h00);
		wr(smr_pkg::HREG_CMD, 8'hC5);
		wr(smr_pkg::HREG_PARAM, 8'h00);
		repeat (6) @(posedge clk);
		#1;
		for (int i = 0; i < 4; i++) chk(r[i], e[i]);
	endtask : t_reset
	task t_sio;
		cfg(smr_pkg::CMD_RST_SIO, 8'h00, 1, smr_pkg::SIO_USED);
		chk({5'h0, dl, cl, nz}, 8'h00);
		chk(pc, smr_pkg::PREFRAME_PLAIN);
		cfg(smr_pkg::CMD_SET_SIO, 8'h05, 1, smr_pkg::SIO_USED);
		chk({5'h0, dl, cl, nz}, 8'h05);
		chk(pc, smr_pkg::PREFRAME_NRZI);
	endtask : t_sio
	task t_xfer;
		@(posedge clk);
		tx_data_need <= 1'b1;
		rx_data_ready <= 1'b1;
		cfg(smr_pkg::CMD_RST_XFER, 8'h00, 2, smr_pkg::ONE_USED);
		chk({4'h0, ti, ri, tdr, rdr}, 8'h03);
		cfg(smr_pkg::CMD_SET_XFER, 8'h01, 2, smr_pkg::ONE_USED);
		chk({4'h0, ti, ri, tdr, rdr}, 8'h0C);
		rd(smr_pkg::HREG_STATUS);
		chk(d & 8'h04, 8'h00);
	endtask : t_xfer
	task t_oper;
		cfg(smr_pkg::CMD_RST_OPER, 8'h00, 0, smr_pkg::OPER_USED);
		chk({5'h0, pe, bm, ha}, 8'h00);
		ev(1'b0, 1'b0);
		ev(1'b1, 1'b1);
		cfg(smr_pkg::CMD_SET_OPER, 8'hFF, 0, smr_pkg::OPER_USED);
		chk({5'h0, pe, bm, ha}, 8'h07);
		ev(1'b0, 1'b1);
		@(posedge clk);
		new_tx_cmd <= 1'b1;
		@(posedge clk);
		new_tx_cmd <= 1'b0;
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		ev(1'b1, 1'b1);
	endtask : t_oper
	task t_flags;
		@(posedge clk);
		char_boundary <= 1'b1;
		sf(1'b0);
		cfg(smr_pkg::CMD_RST_DELAY, 8'h00, 3, smr_pkg::ONE_USED);
		chk({7'h0, ob}, 8'h00);
		sf(1'b1);
		@(posedge clk);
		loop_transmit <= 1'b1;
		sf(1'b0);
		@(posedge clk);
		loop_transmit <= 1'b0;
		sf(1'b1);
		cfg(smr_pkg::CMD_RST_OPER, 8'hFE, 0, smr_pkg::OPER_USED);
		sf(1'b0);
		@(posedge clk);
		tx_active <= 1'b1;
		cfg(smr_pkg::CMD_SET_OPER, 8'h01, 0, smr_pkg::OPER_USED);
		chk({7'h0, send_flags}, 8'h00);
		@(posedge clk);
		tx_active <= 1'b0;
		sf(1'b1);
		cfg(smr_pkg::CMD_SET_DELAY, 8'h01, 3, smr_pkg::ONE_USED);
		chk({7'h0, ob}, 8'h01);
		sf(1'b0);
	endtask : t_flags
////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		{sw_wr, sw_rd, tx_active, char_boundary, loop_transmit} = '0;
		{last_data_taken, final_flag_sent, new_tx_cmd} = '0;
		{tx_data_need, rx_data_ready, sw_addr, sw_wdata} = '0;
		for (int i = 0; i < 4; i++) e[i] = smr_pkg::MODE_RESET;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_sio();
		t_xfer();
		t_oper();
		t_flags();
		complete_run();
	end
endmodule : test_sdlc_mode_register_config
`default_nettype wire
